/* File: core/icop_params.svh */
// Constants of the input-change and output port block.
// Assumes inclusion from the package and the port module only.
`ifndef ICOP_PARAMS_SVH
`define ICOP_PARAMS_SVH

// Field positions inside the serial busy status nibble
`define ICOP_SBS_RX_BIT      1
`define ICOP_SBS_TX_BIT      3

// Port mode zero field positions
`define ICOP_PM0_PU_C_BIT    2
`define ICOP_PM0_PU_D_BIT    3

// Bit of the hold, interrupt and second hold flags owned by these ports
`define ICOP_HEF_PORT_BIT    2
`define ICOP_IEF_PORT_BIT    2
`define ICOP_SECOND_PORT_HOLD_ENABLE_PORT_BIT   0

// External interrupt enable bits on the multi-function port
`define ICOP_XIE0_BIT        2
`define ICOP_XIE1_BIT        3

// Reset values
`define ICOP_NIB_ZERO        4'h0
`define ICOP_BYTE_ZERO       8'h00
`define ICOP_LED_RESET       4'hF

// Serial clocks per transfer and the counter start and step value
`define ICOP_SIO_CLOCKS      4'h8
`define ICOP_SIO_CNT_ONE     4'h1

`endif

/* File: core/icop_pkg.sv */
// Types shared by the input-change and output port block.
// Assumes the constants header sits beside it.
`include "icop_params.svh"

package icop_pkg;

  // Instruction-level operations that the core issues to the ports
  typedef enum logic [3:0] {
    ICOP_NOP,
    ICOP_RD_SBS,
    ICOP_CLR_SBS,
    ICOP_RD_CHG_C,
    ICOP_CLR_CHG_C,
    ICOP_RD_CHG_D,
    ICOP_CLR_CHG_D,
    ICOP_WR_PM0,
    ICOP_WR_PEF,
    ICOP_WR_HEF,
    ICOP_WR_IEF,
    ICOP_WR_SECOND_PORT_HOLD_ENABLE,
    ICOP_WR_SEF,
    ICOP_WR_XIE,
    ICOP_WR_LED,
    ICOP_RD_MF
  } icop_op_e;

  typedef struct packed {
    logic       valid;
    icop_op_e   code;
    logic       sel;    // LED port select: 0 first, 1 second
    logic [7:0] data;   // RAM nibble in [3:0], or immediate
  } icop_op_t;

  typedef struct packed {
    logic [3:0] mf;
    logic [3:0] d;
    logic [3:0] c;
  } icop_pins_t;

endpackage : icop_pkg

/* File: core/icop_ports.sv */
// Input-change ports, LED output ports, multi-function input port and
// serial busy status of a 4-bit controller core.
// Assumes the core issues one operation per cycle, that pins are already
// synchronous in level but may glitch, and that the serial shifter gives
// a start pulse and one pulse per serial clock.
//
// Operation
// [R1] Status bit 1 shows receive busy
// [R2] Status bit 3 shows transmit busy
// [R3] Status readable, cleared by clear instruction
// [R4] Receive busy drops after eight clocks; event
// [R5] First port pull-ups switched by mode
// [R6] Mode bits 2,3 enable pull-ups per port
// [R7] All three enables: change releases hold/interrupts
// [R8] First port change sets its status bit
// [R9] First status read-only, clear instruction only
// [R10] Selected first-port falling edge wakes stop
// [R11] Second port change releases hold, no interrupt
// [R12] Second port change sets its status bit
// [R13] Second status read-only, clear instruction only
// [R14] Selected second-port falling edge wakes stop
// [R15] LED write drives RAM nibble onto port
// [R16] Multi-function read loads RAM and accumulator
// [R17] Pins 2,3 become external interrupts
// [R18] Reset clears all enable flags
// [R19] Change bits sticky; pins synchronised first
`timescale 1ns/1ps
`include "icop_params.svh"

module icop_ports
  import icop_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  // Core operation port
  input  wire icop_op_t   i_op,
  output logic [3:0]      o_rd_data,
  output logic            o_rd_valid,
  output logic            o_acc_load,
  // Serial shifter status
  input  wire logic       i_sio_rx_start,
  input  wire logic       i_sio_tx_start,
  input  wire logic       i_sio_clk_pulse,
  output logic            o_sio_event,
  // Pins
  input  wire icop_pins_t i_pins,
  output logic            o_pullup_c_en,
  output logic            o_pullup_d_en,
  output logic [1:0]      o_open_drain_sel,
  output logic [3:0]      o_led_a,
  output logic [3:0]      o_led_b,
  // Wake and interrupt requests to the core
  output logic            o_port_irq,
  output logic            o_hold_release,
  output logic            o_stop_wake,
  output logic [1:0]      o_ext_irq
);

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  function automatic logic is_op(input icop_op_t op, input icop_op_e c);
    is_op = op.valid && (op.code == c);
  endfunction : is_op

  wire logic rd_sbs    = is_op(i_op, ICOP_RD_SBS);
  wire logic clr_sbs   = is_op(i_op, ICOP_CLR_SBS);
  wire logic rd_chg_c  = is_op(i_op, ICOP_RD_CHG_C);
  wire logic clr_chg_c = is_op(i_op, ICOP_CLR_CHG_C);
  wire logic rd_chg_d  = is_op(i_op, ICOP_RD_CHG_D);
  wire logic clr_chg_d = is_op(i_op, ICOP_CLR_CHG_D);
  wire logic wr_pm0    = is_op(i_op, ICOP_WR_PM0);
  wire logic wr_pef    = is_op(i_op, ICOP_WR_PEF);
  wire logic wr_hef    = is_op(i_op, ICOP_WR_HEF);
  wire logic wr_ief    = is_op(i_op, ICOP_WR_IEF);
  wire logic wr_second_port_hold_enable   = is_op(i_op, ICOP_WR_SECOND_PORT_HOLD_ENABLE);
  wire logic wr_sef    = is_op(i_op, ICOP_WR_SEF);
  wire logic wr_xie    = is_op(i_op, ICOP_WR_XIE);
  wire logic wr_led    = is_op(i_op, ICOP_WR_LED);
  wire logic rd_mf     = is_op(i_op, ICOP_RD_MF);

  // ****************************************************************
  // Write-only control flags
  // ****************************************************************
  logic [3:0] port_mode_zero_r;
  logic [7:0] port_event_enable_r;   // [3:0] first port, [7:4] second
  logic [3:0] hold_release_enable_r;
  logic [3:0] interrupt_enable_flags_r;
  logic [3:0] second_port_hold_enable_r;
  logic [7:0] stop_wake_enable_r;    // [3:0] first port, [7:4] second
  logic [3:0] external_interrupt_enable_r;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      port_mode_zero_r            <= `ICOP_NIB_ZERO;
      port_event_enable_r         <= `ICOP_BYTE_ZERO; // R18
      hold_release_enable_r       <= `ICOP_NIB_ZERO;  // R18
      interrupt_enable_flags_r    <= `ICOP_NIB_ZERO;  // R18
      second_port_hold_enable_r   <= `ICOP_NIB_ZERO;  // R18
      stop_wake_enable_r          <= `ICOP_BYTE_ZERO; // R18
      external_interrupt_enable_r <= `ICOP_NIB_ZERO;  // R18
    end else begin
      if (wr_pm0)  port_mode_zero_r            <= i_op.data[3:0];
      if (wr_pef)  port_event_enable_r         <= i_op.data;
      if (wr_hef)  hold_release_enable_r       <= i_op.data[3:0];
      if (wr_ief)  interrupt_enable_flags_r    <= i_op.data[3:0];
      if (wr_second_port_hold_enable) second_port_hold_enable_r   <= i_op.data[3:0];
      if (wr_sef)  stop_wake_enable_r          <= i_op.data;
      if (wr_xie)  external_interrupt_enable_r <= i_op.data[3:0];
    end
  end

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  // Stage one feeds stage two only; edges compare stages two and three
  // Stages preset high, the level of an idle pulled-up pin
  logic [11:0] pin_s1_r;
  logic [11:0] pin_s2_r;
  logic [11:0] pin_s3_r;
  logic [11:0] pin_change;
  logic [11:0] pin_fall;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1_r <= 12'hFFF;
      pin_s2_r <= 12'hFFF;
      pin_s3_r <= 12'hFFF;
    end else begin
      pin_s1_r <= i_pins;   // R19
      pin_s2_r <= pin_s1_r; // R19
      pin_s3_r <= pin_s2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_edge
      assign pin_change[gi] = pin_s2_r[gi] ^ pin_s3_r[gi];
      assign pin_fall[gi]   = pin_s3_r[gi] & ~pin_s2_r[gi];
    end
  endgenerate

  wire logic [3:0] chg_c  = pin_change[3:0];
  wire logic [3:0] chg_d  = pin_change[7:4];
  wire logic [3:0] fall_m = pin_fall[11:8];

  // ****************************************************************
  // Sticky change flags
  // ****************************************************************
  logic [3:0] first_input_change_flags_r;
  logic [3:0] second_input_change_flags_r;

  // Either edge counts as a change; the flag stays until cleared
  // A change in the clearing cycle survives the clear
  wire logic [3:0] chg_flags_c_nxt =
    (clr_chg_c ? `ICOP_NIB_ZERO : first_input_change_flags_r)
    | chg_c; // R8
  wire logic [3:0] chg_flags_d_nxt =
    (clr_chg_d ? `ICOP_NIB_ZERO : second_input_change_flags_r)
    | chg_d; // R12

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first_input_change_flags_r  <= `ICOP_NIB_ZERO;
      second_input_change_flags_r <= `ICOP_NIB_ZERO;
    end else begin
      first_input_change_flags_r  <= chg_flags_c_nxt; // R9 R19
      second_input_change_flags_r <= chg_flags_d_nxt; // R13 R19
    end
  end

  // ****************************************************************
  // Hold release, interrupt, stop wake and external interrupts
  // ****************************************************************
  wire logic hef_c  = hold_release_enable_r[`ICOP_HEF_PORT_BIT];
  wire logic ief_c  = interrupt_enable_flags_r[`ICOP_IEF_PORT_BIT];
  wire logic second_port_hold_enable_d = second_port_hold_enable_r[`ICOP_SECOND_PORT_HOLD_ENABLE_PORT_BIT];

  // The second port only releases hold; it has no interrupt path
  // Only pins selected by the event enables can raise an interrupt or hold release
  wire logic ev_c = |(chg_c & port_event_enable_r[3:0]);
  wire logic ev_d = |(chg_d & port_event_enable_r[7:4]);

  wire logic irq_nxt  = ev_c & hef_c & ief_c;            // R7
  wire logic hold_nxt = (ev_c & hef_c & ief_c)           // R7
                      | (ev_d & second_port_hold_enable_d);                 // R11
  wire logic wake_nxt =
    |(pin_fall[3:0] & stop_wake_enable_r[3:0])           // R10
    | |(pin_fall[7:4] & stop_wake_enable_r[7:4]);        // R14
  // External interrupts fire on the falling edge of their pin
  wire logic [1:0] xirq_nxt = {
    fall_m[3] & external_interrupt_enable_r[`ICOP_XIE1_BIT],
    fall_m[2] & external_interrupt_enable_r[`ICOP_XIE0_BIT]
  }; // R17

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_port_irq     <= 1'b0;
      o_hold_release <= 1'b0;
      o_stop_wake    <= 1'b0;
      o_ext_irq      <= 2'h0;
    end else begin
      o_port_irq     <= irq_nxt;  // R7
      o_hold_release <= hold_nxt; // R7 R11
      o_stop_wake    <= wake_nxt; // R10 R14
      o_ext_irq      <= xirq_nxt; // R17
    end
  end

  // ****************************************************************
  // Serial busy status
  // ****************************************************************
  logic       receive_busy_flag_r;
  logic       transmit_busy_flag_r;
  logic [3:0] sio_cnt_r;

  wire logic any_busy  = receive_busy_flag_r | transmit_busy_flag_r;
  wire logic sio_start = i_sio_rx_start | i_sio_tx_start;
  wire logic sio_last  = any_busy & i_sio_clk_pulse
                       & (sio_cnt_r == `ICOP_SIO_CLOCKS);
  // One counter serves both directions, so one transfer at a time
  // A clear stops the busy bits but leaves the count for the next start
  // A new start wins over both the clear and the end of transfer
  wire logic rx_busy_nxt = i_sio_rx_start
    | (receive_busy_flag_r & ~sio_last & ~clr_sbs);      // R4 R3
  wire logic tx_busy_nxt = i_sio_tx_start
    | (transmit_busy_flag_r & ~sio_last & ~clr_sbs);     // R3
  wire logic [3:0] sio_cnt_nxt =
    sio_start ? `ICOP_SIO_CNT_ONE :
    (any_busy & i_sio_clk_pulse) ? sio_cnt_r + `ICOP_SIO_CNT_ONE :
    sio_cnt_r;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      receive_busy_flag_r  <= 1'b0;
      transmit_busy_flag_r <= 1'b0;
      sio_cnt_r            <= `ICOP_SIO_CNT_ONE;
      o_sio_event          <= 1'b0;
    end else begin
      receive_busy_flag_r  <= rx_busy_nxt;
      transmit_busy_flag_r <= tx_busy_nxt;
      sio_cnt_r            <= sio_cnt_nxt;
      o_sio_event          <= sio_last & ~sio_start; // R4
    end
  end

  // Reserved status bits read back as zero
  wire logic [3:0] sbs_value = {
    transmit_busy_flag_r,  // R2
    1'b0,
    receive_busy_flag_r,   // R1
    1'b0
  };

  // ****************************************************************
  // Read path
  // ****************************************************************
  // One read per cycle; the answer follows one edge later
  wire logic [3:0] rd_sel =
    rd_sbs   ? sbs_value :                    // R3
    rd_chg_c ? first_input_change_flags_r :   // R9
    rd_chg_d ? second_input_change_flags_r :  // R13
    rd_mf    ? pin_s2_r[11:8] :               // R16
               `ICOP_NIB_ZERO;
  wire logic rd_any = rd_sbs | rd_chg_c | rd_chg_d | rd_mf;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data  <= `ICOP_NIB_ZERO;
      o_rd_valid <= 1'b0;
      o_acc_load <= 1'b0;
    end else begin
      o_rd_data  <= rd_sel;
      o_rd_valid <= rd_any;
      o_acc_load <= rd_mf; // R16
    end
  end

  // ****************************************************************
  // Pull-ups, output type and LED ports
  // ****************************************************************
  // LED ports come out of reset high, as the pins do
  wire logic led_a_we = wr_led & ~i_op.sel;
  wire logic led_b_we = wr_led & i_op.sel;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pullup_c_en    <= 1'b0;
      o_pullup_d_en    <= 1'b0;
      o_open_drain_sel <= 2'h0;
      o_led_a          <= `ICOP_LED_RESET;
      o_led_b          <= `ICOP_LED_RESET;
    end else begin
      o_pullup_c_en    <= port_mode_zero_r[`ICOP_PM0_PU_C_BIT]; // R5 R6
      o_pullup_d_en    <= port_mode_zero_r[`ICOP_PM0_PU_D_BIT]; // R6
      o_open_drain_sel <= port_mode_zero_r[1:0];
      if (led_a_we) o_led_a <= i_op.data[3:0]; // R15
      if (led_b_we) o_led_b <= i_op.data[3:0]; // R15
    end
  end

endmodule : icop_ports

/* File: test/icop_pin_model.sv */
// Keys and level sources on the input pins.
// Assumes the bench presses keys; pull-up enables come from the block.
`timescale 1ns/1ps
module icop_pin_model
  import icop_pkg::*;
(
  // Clock and pull-up controls
  input  wire logic       i_ref_clk,
  input  wire logic       i_pu_c,
  input  wire logic       i_pu_d,
  // Key closures, 1 grounds the pin; level pins
  input  wire logic [7:0] i_press,
  input  wire logic [3:0] i_mf,
  output icop_pins_t      o_pins
);
  // ****************************************
  // Pin levels
  // ****************************************
  logic fl_r = 1'b0;
  // Open pin without pull-up wanders, so nothing may rely on it
  always_ff @(posedge i_ref_clk) begin
    fl_r <= ~fl_r;
  end
  assign o_pins = '{mf: i_mf,
                    d:  ~i_press[7:4] & {4{i_pu_d | fl_r}},
                    c:  ~i_press[3:0] & {4{i_pu_c | fl_r}}};
endmodule : icop_pin_model

/* File: test/icop_ports_sva.sv */
// Port-level checker for the input-change and output port block.
// Assumes it is bound into icop_ports and sees only its ports.
`timescale 1ns/1ps
module icop_ports_sva
  import icop_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_reset_n,
  input wire icop_op_t   i_op,
  input wire logic [3:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic       o_acc_load,
  input wire logic       i_sio_rx_start,
  input wire logic       i_sio_tx_start,
  input wire logic       i_sio_clk_pulse,
  input wire logic       o_sio_event,
  input wire logic       o_pullup_c_en,
  input wire logic       o_pullup_d_en,
  input wire logic [3:0] o_led_a,
  input wire logic [3:0] o_led_b,
  input wire logic       o_port_irq,
  input wire logic       o_hold_release
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  wire is_sbs = i_op.valid && i_op.code == ICOP_RD_SBS;
  wire is_pm0 = i_op.valid && i_op.code == ICOP_WR_PM0;
  wire is_rd  = i_op.valid && i_op.code inside
                {ICOP_RD_SBS, ICOP_RD_CHG_C, ICOP_RD_CHG_D, ICOP_RD_MF};
  sequence s_led(logic s);
    i_op.valid && i_op.code == ICOP_WR_LED && i_op.sel == s;
  endsequence
  sequence s_rx_go;
    i_sio_rx_start && !i_sio_tx_start ##1 is_sbs;
  endsequence
  property p_rd_ans; is_rd |=> o_rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_no_ans; !is_rd |=> !o_rd_valid && !o_acc_load; endproperty
  a_no_ans: assert property (p_no_ans) else $error("stray answer");
  property p_acc;
    o_acc_load |-> o_rd_valid && $past(i_op.code) == ICOP_RD_MF;
  endproperty
  a_acc: assert property (p_acc) else $error("bad acc load");
  property p_led_a;
    s_led(1'b0) |=> o_led_a == $past(i_op.data[3:0]) && $stable(o_led_b);
  endproperty
  a_led_a: assert property (p_led_a) else $error("led a wrong");
  property p_led_b;
    s_led(1'b1) |=> o_led_b == $past(i_op.data[3:0]) && $stable(o_led_a);
  endproperty
  a_led_b: assert property (p_led_b) else $error("led b wrong");
  property p_sbs_res; is_sbs |=> !o_rd_data[0] && !o_rd_data[2]; endproperty
  a_sbs_res: assert property (p_sbs_res) else $error("reserved set");
  property p_rx_bit; s_rx_go |=> o_rd_data[1]; endproperty
  a_rx_bit: assert property (p_rx_bit) else $error("rx busy low");
  property p_pullup;
    is_pm0 ##1 !is_pm0 |=> o_pullup_c_en == $past(i_op.data[2], 2)
      && o_pullup_d_en == $past(i_op.data[3], 2);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");
  property p_irq_hold; o_port_irq |-> o_hold_release; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq alone");
  property p_event; o_sio_event |-> $past(i_sio_clk_pulse); endproperty
  a_event: assert property (p_event) else $error("event no clock");
endmodule : icop_ports_sva

bind icop_ports icop_ports_sva u_sva(.i_ref_clk, .i_reset_n, .i_op,
  .o_rd_data, .o_rd_valid, .o_acc_load, .i_sio_rx_start, .i_sio_tx_start,
  .i_sio_clk_pulse, .o_sio_event, .o_pullup_c_en, .o_pullup_d_en,
  .o_led_a, .o_led_b, .o_port_irq, .o_hold_release);

/* File: test/test_icop_ports.sv */
// Self-checking bench for the input-change and output port block.
// Assumes the checker is bound in and the pin model drives the pins.
`timescale 1ns/1ps
module test_icop_ports
  import icop_pkg::*;
;
  logic       i_ref_clk = 1'b0;
  logic       i_reset_n = 1'b0;
  icop_op_t   i_op = '0;
  logic       rx = 1'b0, tx = 1'b0, sck = 1'b0;
  logic [7:0] press = 8'h00, sev;
  logic [3:0] mf = 4'hD, ev, rd_data, led_a, led_b;
  logic       rd_valid, acc_load, sio_ev, pu_c, pu_d, irq, hold, wake;
  logic [1:0] ext, ods;
  icop_pins_t pins;
  int         fail_count = 0, comparisons = 0;

  always #2.5 i_ref_clk = ~i_ref_clk;

  icop_ports uut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_op(i_op), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_acc_load(acc_load), .i_sio_rx_start(rx), .i_sio_tx_start(tx),
    .i_sio_clk_pulse(sck), .o_sio_event(sio_ev), .i_pins(pins),
    .o_pullup_c_en(pu_c), .o_pullup_d_en(pu_d), .o_open_drain_sel(ods),
    .o_led_a(led_a), .o_led_b(led_b), .o_port_irq(irq),
    .o_hold_release(hold), .o_stop_wake(wake), .o_ext_irq(ext));
  icop_pin_model u_pins (.i_ref_clk(i_ref_clk), .i_pu_c(pu_c),
    .i_pu_d(pu_d), .i_press(press), .i_mf(mf), .o_pins(pins));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // Returns just after the taking edge, when a read answer shows
  task automatic op(input icop_op_e c, input logic [7:0] d,
                    input logic s = 1'b0);
    @(posedge i_ref_clk); #1;
    i_op = '{1'b1, c, s, d};
    @(posedge i_ref_clk); #1;
    i_op = '0;
  endtask : op
  task automatic rd(input icop_op_e c, input logic [3:0] exp);
    op(c, 8'h00);
    check({3'b000, rd_valid}, 4'h1);
    check(rd_data, exp);
  endtask : rd
  task automatic watch(input int n);
    ev = 4'h0;
    repeat (n) begin
      @(posedge i_ref_clk); #1;
      ev |= {|ext, irq, hold, wake};
    end
  endtask : watch
  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    check(led_a, 4'hF);
    check({ods, pu_d, pu_c}, 4'h0);
    watch(6); check(ev, 4'h0);
    op(ICOP_WR_PM0, 8'h08);
    watch(1);
    check({ods, pu_d, pu_c}, 4'h2);
    op(ICOP_WR_PM0, 8'h0D);
    watch(1);
    check({ods, pu_d, pu_c}, 4'h7);
    watch(5);
    op(ICOP_CLR_CHG_C, 8'h00);
    op(ICOP_CLR_CHG_D, 8'h00);
    rd(ICOP_RD_CHG_C, 4'h0);
    rd(ICOP_RD_CHG_D, 4'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_led;
    op(ICOP_WR_LED, 8'h05, 1'b0); check(led_a, 4'h5); check(led_b, 4'hF);
    op(ICOP_WR_LED, 8'hFA, 1'b1); check(led_b, 4'hA); check(led_a, 4'h5);
    $display("t_led done");
  endtask : t_led
  task automatic t_chg_c;
    op(ICOP_WR_PEF, 8'h01); op(ICOP_WR_HEF, 8'h04);
    op(ICOP_WR_IEF, 8'h04); op(ICOP_WR_SEF, 8'h01);
    press[0] = 1'b1; watch(6); check(ev, 4'h7);
    rd(ICOP_RD_CHG_C, 4'h1);
    press[0] = 1'b0; watch(6); check(ev, 4'h6);
    rd(ICOP_RD_CHG_C, 4'h1);
    press[1] = 1'b1; watch(6); check(ev, 4'h0);
    rd(ICOP_RD_CHG_C, 4'h3);
    press[1] = 1'b0; watch(6);
    op(ICOP_CLR_CHG_C, 8'h00); rd(ICOP_RD_CHG_C, 4'h0);
    $display("t_chg_c done");
  endtask : t_chg_c
  task automatic t_chg_d;
    op(ICOP_WR_PEF, 8'h20); op(ICOP_WR_SECOND_PORT_HOLD_ENABLE, 8'h01); op(ICOP_WR_SEF, 8'h20);
    press[5] = 1'b1; watch(6); check(ev, 4'h3);
    rd(ICOP_RD_CHG_D, 4'h2);
    rd(ICOP_RD_CHG_C, 4'h0);
    press[5] = 1'b0; watch(6);
    op(ICOP_CLR_CHG_D, 8'h00); rd(ICOP_RD_CHG_D, 4'h0);
    $display("t_chg_d done");
  endtask : t_chg_d
  task automatic t_sio;
    @(posedge i_ref_clk); #1; rx = 1'b1;
    rd(ICOP_RD_SBS, 4'h2);
    rx = 1'b0;
    sev = 8'h00;
    repeat (8) begin
      @(posedge i_ref_clk); #1; sck = 1'b1;
      @(posedge i_ref_clk); #1; sck = 1'b0;
      sev = {sev[6:0], sio_ev};
    end
    check(sev[7:4], 4'h0); check(sev[3:0], 4'h1);
    rd(ICOP_RD_SBS, 4'h0);
    @(posedge i_ref_clk); #1; tx = 1'b1;
    rd(ICOP_RD_SBS, 4'h8);
    tx = 1'b0;
    op(ICOP_CLR_SBS, 8'h00); rd(ICOP_RD_SBS, 4'h0);
    $display("t_sio done");
  endtask : t_sio
  task automatic t_mf;
    op(ICOP_RD_MF, 8'h00);
    check({3'b000, acc_load}, 4'h1); check(rd_data, 4'hD);
    op(ICOP_WR_XIE, 8'h08);
    mf = 4'h9; watch(6); check(ev, 4'h0);
    mf = 4'h1; watch(6); check(ev, 4'h8);
    mf = 4'hD;
    watch(6);
    op(ICOP_WR_XIE, 8'h04);
    mf = 4'h9;
    watch(6);
    check(ev, 4'h8);
    $display("t_mf done");
  endtask : t_mf

  initial begin
    repeat (6) @(posedge i_ref_clk);
    #1 i_reset_n = 1'b1;
    t_reset();
    t_led();
    t_chg_c();
    t_chg_d();
    t_sio();
    t_mf();
    end_sim();
  end
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
endmodule : test_icop_ports
